// ==== rtl/swm_regs_pkg.sv ====
// package for the single-wire master register bank: codes, layouts, timing
`default_nettype none
package swm_regs_pkg;
    // pointer codes selecting the register the host reads next
    localparam logic [7:0] PTR_STATUS    = 8'hF0;
    localparam logic [7:0] PTR_READ_DATA = 8'hE1;
    localparam logic [7:0] PTR_CONFIG    = 8'hC3;
    // command codes
    localparam logic [7:0] CMD_DEV_RESET = 8'hF0;
    localparam logic [7:0] CMD_SET_PTR   = 8'hE1;
    localparam logic [7:0] CMD_WR_CONFIG = 8'hD2;
    localparam logic [7:0] CMD_BUS_RESET = 8'hB4;
    localparam logic [7:0] CMD_SINGLE    = 8'h87;
    localparam logic [7:0] CMD_WR_BYTE   = 8'hA5;
    localparam logic [7:0] CMD_RD_BYTE   = 8'h96;
    localparam logic [7:0] CMD_TRIPLET   = 8'h78;
    // configuration field positions
    localparam int CFG_APU_BIT = 0;
    localparam int CFG_ZERO_BIT = 1;
    localparam int CFG_SPU_BIT = 2;
    localparam int CFG_OVD_BIT = 3;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    // status field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_PRES  = 1;
    localparam int ST_SHORT = 2;
    localparam int ST_LINE  = 3;
    localparam int ST_RST   = 4;
    localparam int ST_SBR   = 5;
    localparam int ST_TSB   = 6;
    localparam int ST_DIR   = 7;
    localparam logic [7:0] STATUS_RESET_VAL = 8'h10;
    // slot timing, figures in microseconds, counts in 50 ns cycles
    localparam int CLK_NS         = 50;
    localparam int STD_SLOT_US    = 65;
    localparam int STD_SLOT_CYC   = (STD_SLOT_US * 1000) / CLK_NS;
    localparam int OVD_SLOT_US    = 10;
    localparam int OVD_SLOT_CYC   = (OVD_SLOT_US * 1000) / CLK_NS;
    localparam int STD_RESET_US   = 960;
    localparam int STD_RESET_CYC  = (STD_RESET_US * 1000) / CLK_NS;
    localparam int OVD_RESET_US   = 140;
    localparam int OVD_RESET_CYC  = (OVD_RESET_US * 1000) / CLK_NS;
    localparam int APU_TIMEOUT_US = 2;
    localparam int APU_TIMEOUT_CYC = (APU_TIMEOUT_US * 1000) / CLK_NS;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // pointer selection
    typedef enum logic [1:0] {SEL_STATUS, SEL_DATA, SEL_CONFIG} swm_ptr_type;
    // bus-side command issued to the slot engine
    typedef struct packed {
        logic       start;
        logic [7:0] code;
        logic [7:0] data;
    } swm_cmd_type;
endpackage
`default_nettype wire

// ==== rtl/swm_regs.sv ====
// register bank and slot sequencer of the single-wire bus master bridge
`default_nettype none
// Overview of operation
// - read pointer picks one of three registers
// - config reads 00h after any reset
// - config write needs complemented upper nibble
// - config upper nibble reads as zero
// - config bits: active, zero, strong, overdrive
// - status bits busy through branch direction
// - active pullup after threshold until timeout
// - strong pullup holds until command, clear, reset
// - external pullup control low while strong
// - strong enable self-clears, others kept
// - slot length follows the speed select
// - busy high throughout bus activity
// - presence captured each bus reset
// - short captured; short forces presence low
// - line level sampled at read addressing with pointer at status
// - reset flag set on reset, cleared by config
// - single bit result from slot sample
// - triplet updates second bit and direction
// - device reset clears result flags and config, sets reset flag
// - config write refused while busy
// - only three pointer codes accepted
module swm_regs
    import swm_regs_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        rstn,
    // command port from the host-side protocol engine
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [7:0]  cmdParam,
    output logic             cmdAck,
    input  wire logic        readAddrAck,
    input  wire logic [7:0]  readDataIn,
    output logic [7:0]       readData,
    // bus line
    input  wire logic        lineClk,
    input  wire logic        lineIn,
    output logic             lineOut,
    output logic             lineOe,
    output logic             pullupOn,
    output logic             ext_pullup_ctrl_n
);
    //------------------------------------------------------------------
    // host-side state
    //------------------------------------------------------------------
    swm_ptr_type ptr_r;             // read pointer
    logic [3:0]  cfg_r;             // stored lower config nibble
    logic        pres_r, short_r, line_r, rst_r, sbr_r, tsb_r, dir_r;
    logic        busyReq_r;         // toggles to start a link job
    logic        doneSync1_r, doneSync2_r, doneSeen_r;
    logic        lineSync1_r, lineSync2_r;
    logic        busy;
    logic        isComm;
    logic        cfgOk;
    logic        spuEnd;            // strong pullup ended (host domain)
    logic        spuArmed_r;        // a launched job owns the strong pullup
    logic        endSync1_r, endSync2_r, endSeen_r;
    logic [2:0]  resSync1_r, resSync2_r;

    // link completion arrives as a toggle
    logic        doneTog_r;
    logic        endTog_r;
    logic [2:0]  res_r;             // presence/short or bit results
    logic [2:0]  resL_r;            // results held in link domain
    logic        reqS1_r, reqS2_r, reqSeen_r;
    logic [7:0]  jobCode_r, jobData_r;
    logic        jobOvd_r, jobSpu_r, jobApu_r;

    // comm command decode
    function automatic logic is_comm(input logic [7:0] c);
        return (c == CMD_BUS_RESET) || (c == CMD_SINGLE) || (c == CMD_WR_BYTE)
            || (c == CMD_RD_BYTE) || (c == CMD_TRIPLET);
    endfunction

    assign isComm = cmdValid && is_comm(cmdCode);
    assign busy   = busyReq_r != doneSeen_r;
    assign cfgOk  = (cmdParam[7:4] == ~cmdParam[3:0]);
    assign spuEnd = endSync2_r != endSeen_r;

    // acknowledge decode; refusals are shown by a low ack
    always_comb
    begin
        cmdAck = 1'b0;
        if (cmdValid)
        begin
            unique case (cmdCode)
                CMD_DEV_RESET: cmdAck = 1'b1;
                CMD_SET_PTR:   cmdAck = (cmdParam == PTR_STATUS) ||
                                        (cmdParam == PTR_READ_DATA) ||
                                        (cmdParam == PTR_CONFIG);
                CMD_WR_CONFIG: cmdAck = !busy && cfgOk;
                default:       cmdAck = is_comm(cmdCode) && !busy;
            endcase
        end
    end

    //------------------------------------------------------------------
    // read pointer
    //------------------------------------------------------------------
    // pointer only moves on commands, never on reads
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ptr_r <= SEL_STATUS;
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
            ptr_r <= SEL_STATUS;
        else if (isComm && cmdAck)
            ptr_r <= SEL_STATUS;
        else if (cmdValid && cmdCode == CMD_SET_PTR && cmdAck)
        begin
            if (cmdParam == PTR_STATUS)
                ptr_r <= SEL_STATUS;
            else if (cmdParam == PTR_READ_DATA)
                ptr_r <= SEL_DATA;
            else
                ptr_r <= SEL_CONFIG;
        end
    end

    // read mux; upper config nibble always reads zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            readData <= 8'h00;
        else
        begin
            unique case (ptr_r)
                SEL_STATUS: readData <= {dir_r, tsb_r, sbr_r, rst_r, line_r,
                                         short_r, pres_r, busy};
                SEL_DATA:   readData <= readDataIn;
                SEL_CONFIG: readData <= {4'h0, cfg_r};
            endcase
        end
    end

    //------------------------------------------------------------------
    // configuration register
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cfg_r <= CFG_RESET_VAL[3:0];
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
            cfg_r <= CFG_RESET_VAL[3:0];
        else if (cmdValid && cmdCode == CMD_WR_CONFIG && cmdAck)
        begin
            cfg_r <= cmdParam[3:0];
            cfg_r[CFG_ZERO_BIT] <= 1'b0;
        end
        else if (spuEnd)
            cfg_r[CFG_SPU_BIT] <= 1'b0;
    end

    //------------------------------------------------------------------
    // status flags
    //------------------------------------------------------------------
    // reset flag: set on any reset, cleared by accepted config write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_r <= 1'b1;
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
            rst_r <= 1'b1;
        else if (cmdValid && cmdCode == CMD_WR_CONFIG && cmdAck)
            rst_r <= 1'b0;
    end

    // results captured when the link reports completion
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pres_r  <= 1'b0;
            short_r <= 1'b0;
            sbr_r   <= 1'b0;
            tsb_r   <= 1'b0;
            dir_r   <= 1'b0;
        end
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
        begin
            pres_r  <= 1'b0;
            short_r <= 1'b0;
            sbr_r   <= 1'b0;
            tsb_r   <= 1'b0;
            dir_r   <= 1'b0;
        end
        else if (busy && doneSync2_r != doneSeen_r)
        begin
            unique case (jobCode_r)
                CMD_BUS_RESET:
                begin
                    short_r <= resSync2_r[1];
                    pres_r  <= resSync2_r[0] && !resSync2_r[1];
                end
                CMD_SINGLE: sbr_r <= resSync2_r[0];
                CMD_TRIPLET:
                begin
                    sbr_r <= resSync2_r[0];
                    tsb_r <= resSync2_r[1];
                    dir_r <= resSync2_r[2];
                end
                default: ;
            endcase
        end
    end

    // line level sampled at read addressing with pointer at status
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            line_r <= 1'b0;
        else if (readAddrAck && ptr_r == SEL_STATUS)
            line_r <= lineSync2_r;
    end

    //------------------------------------------------------------------
    // job launch and crossings
    //------------------------------------------------------------------
    // job fields are held stable while the toggle crosses
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busyReq_r <= 1'b0;
            jobCode_r <= 8'h00;
            jobData_r <= 8'h00;
            jobOvd_r  <= 1'b0;
            jobSpu_r  <= 1'b0;
            jobApu_r  <= 1'b0;
        end
        else if (isComm && cmdAck)
        begin
            busyReq_r <= ~busyReq_r;
            jobCode_r <= cmdCode;
            jobData_r <= cmdParam;
            jobOvd_r  <= cfg_r[CFG_OVD_BIT];
            jobSpu_r  <= cfg_r[CFG_SPU_BIT] && !spuArmed_r;
            jobApu_r  <= cfg_r[CFG_APU_BIT];
        end
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
        begin
            // an aborted job must not land stale results on cleared flags
            jobCode_r <= 8'h00;
            jobSpu_r  <= 1'b0;
        end
    end

    // the command that ends a strong pullup must not start a new one,
    // since the enable bit only clears once the end has crossed back
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            spuArmed_r <= 1'b0;
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
            spuArmed_r <= 1'b0;
        else if (isComm && cmdAck)
            spuArmed_r <= cfg_r[CFG_SPU_BIT] && !spuArmed_r;
        else if (spuEnd)
            spuArmed_r <= 1'b0;
    end

    // two-stage synchronisers into the host clock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            doneSync1_r <= 1'b0;
            doneSync2_r <= 1'b0;
            doneSeen_r  <= 1'b0;
            endSync1_r  <= 1'b0;
            endSync2_r  <= 1'b0;
            endSeen_r   <= 1'b0;
            lineSync1_r <= 1'b1;
            lineSync2_r <= 1'b1;
            resSync1_r  <= 3'h0;
            resSync2_r  <= 3'h0;
        end
        else
        begin
            doneSync1_r <= doneTog_r;
            doneSync2_r <= doneSync1_r;
            doneSeen_r  <= doneSync2_r;
            endSync1_r  <= endTog_r;
            endSync2_r  <= endSync1_r;
            endSeen_r   <= endSync2_r;
            lineSync1_r <= lineIn;
            lineSync2_r <= lineSync1_r;
            resSync1_r  <= resL_r;
            resSync2_r  <= resSync1_r;
        end
    end

    //------------------------------------------------------------------
    // link domain slot engine
    //------------------------------------------------------------------
    typedef enum logic [1:0] {L_IDLE, L_LOW, L_REL, L_DONE} swm_link_type;
    swm_link_type lst_r;
    logic [15:0]  cnt_r;
    logic [3:0]   bitIdx_r;
    logic [3:0]   nBits;
    logic         spuHold_r;
    logic [5:0]   apuCnt_r;
    logic         lineL1_r, lineL2_r;
    logic         cfgSpuS1_r, cfgSpuS2_r;
    logic         devRstTog_r, devRstS1_r, devRstS2_r, devRstSeen_r;
    logic [15:0]  slotLen;

    assign slotLen = jobOvd_r ? 16'(OVD_SLOT_CYC) : 16'(STD_SLOT_CYC);
    assign nBits   = (jobCode_r == CMD_TRIPLET) ? 4'd3 :
                     (jobCode_r == CMD_SINGLE || jobCode_r == CMD_BUS_RESET) ? 4'd1 : 4'd8;

    // device reset crosses as a toggle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            devRstTog_r <= 1'b0;
        else if (cmdValid && cmdCode == CMD_DEV_RESET)
            devRstTog_r <= ~devRstTog_r;
    end

    always_ff @(posedge lineClk or negedge rstn)
    begin
        if (!rstn)
        begin
            reqS1_r <= 1'b0; reqS2_r <= 1'b0;
            lineL1_r <= 1'b1; lineL2_r <= 1'b1;
            cfgSpuS1_r <= 1'b0; cfgSpuS2_r <= 1'b0;
            devRstS1_r <= 1'b0; devRstS2_r <= 1'b0;
        end
        else
        begin
            reqS1_r <= busyReq_r; reqS2_r <= reqS1_r;
            lineL1_r <= lineIn; lineL2_r <= lineL1_r;
            cfgSpuS1_r <= cfg_r[CFG_SPU_BIT]; cfgSpuS2_r <= cfgSpuS1_r;
            devRstS1_r <= devRstTog_r; devRstS2_r <= devRstS1_r;
        end
    end

    // slot sequencer: low phase, release, sample at quarter-slot
    always_ff @(posedge lineClk or negedge rstn)
    begin
        if (!rstn)
        begin
            lst_r <= L_IDLE; cnt_r <= 16'h0000; bitIdx_r <= 4'h0;
            reqSeen_r <= 1'b0; doneTog_r <= 1'b0; resL_r <= 3'h0;
            devRstSeen_r <= 1'b0;
        end
        else if (devRstS2_r != devRstSeen_r)
        begin
            devRstSeen_r <= devRstS2_r;
            if (lst_r != L_IDLE) doneTog_r <= ~doneTog_r;
            lst_r <= L_IDLE;
            reqSeen_r <= reqS2_r;
        end
        else
        begin
            unique case (lst_r)
                L_IDLE:
                    if (reqS2_r != reqSeen_r)
                    begin
                        reqSeen_r <= reqS2_r;
                        lst_r <= L_LOW; cnt_r <= 16'h0000; bitIdx_r <= 4'h0;
                    end
                L_LOW:
                begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r >= (slotLen >> 3)) lst_r <= L_REL;
                end
                L_REL:
                begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == (slotLen >> 2))
                    begin
                        if (jobCode_r == CMD_BUS_RESET)
                            resL_r[1] <= !lineL2_r;
                        else if (bitIdx_r == 4'h2)
                            resL_r[2] <= resL_r[0] ? 1'b1 : 1'b0;
                        else
                            resL_r[bitIdx_r[1:0]] <= lineL2_r;
                    end
                    // presence is judged later than the short, once the line recovered
                    if (jobCode_r == CMD_BUS_RESET && cnt_r == (slotLen >> 1))
                        resL_r[0] <= !lineL2_r;
                    if (cnt_r >= slotLen - 16'h0001)
                    begin
                        if (bitIdx_r + 4'h1 >= nBits) lst_r <= L_DONE;
                        else
                        begin
                            bitIdx_r <= bitIdx_r + 4'h1;
                            cnt_r <= 16'h0000; lst_r <= L_LOW;
                        end
                    end
                end
                L_DONE:
                begin
                    doneTog_r <= ~doneTog_r;
                    lst_r <= L_IDLE;
                end
            endcase
        end
    end

    // active and strong pullup control on the rising edge
    always_ff @(posedge lineClk or negedge rstn)
    begin
        if (!rstn)
        begin
            apuCnt_r <= 6'h00; spuHold_r <= 1'b0; endTog_r <= 1'b0;
        end
        else
        begin
            if (lst_r == L_REL && lineL2_r && apuCnt_r == 6'h00 && jobApu_r
                && jobCode_r != CMD_BUS_RESET)
                apuCnt_r <= 6'(APU_TIMEOUT_CYC);
            else if (apuCnt_r != 6'h00)
                apuCnt_r <= apuCnt_r - 6'h01;
            if (lst_r == L_DONE && jobSpu_r)
                spuHold_r <= 1'b1;
            else if (spuHold_r && (reqS2_r != reqSeen_r || !cfgSpuS2_r
                     || devRstS2_r != devRstSeen_r))
            begin
                spuHold_r <= 1'b0;
                endTog_r <= ~endTog_r;
            end
        end
    end

    assign lineOut = 1'b0;
    assign lineOe  = (lst_r == L_LOW);
    assign pullupOn = spuHold_r || (apuCnt_r != 6'h00);
    assign ext_pullup_ctrl_n = !spuHold_r;

    // busy is up in the cycle after acceptance
    property p_busy_hold;
        @(posedge clk) disable iff (!rstn)
        (isComm && cmdAck) |=> busy;
    endproperty
    a_busy_on_cmd: assert property (p_busy_hold) else $error("busy not raised");
    a_cfg_refused: assert property (@(posedge clk) disable iff (!rstn)
        (cmdValid && cmdCode == CMD_WR_CONFIG && busy) |-> !cmdAck)
        else $error("config accepted while busy");
    a_cfg_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
        (ptr_r == SEL_CONFIG) |=> (readData[7:4] == 4'h0))
        else $error("config upper nibble nonzero");
    a_short_pres: assert property (@(posedge clk) disable iff (!rstn)
        short_r |-> !pres_r) else $error("presence with short");
    a_ext_pullup: assert property (@(posedge lineClk) disable iff (!rstn)
        ext_pullup_ctrl_n == !spuHold_r) else $error("ext pullup mismatch");
    a_dev_reset: assert property (@(posedge clk) disable iff (!rstn)
        (cmdValid && cmdCode == CMD_DEV_RESET) |=> (rst_r && cfg_r == 4'h0
        && ptr_r == SEL_STATUS)) else $error("device reset incomplete");
    a_cfg_check: assert property (@(posedge clk) disable iff (!rstn)
        (cmdValid && cmdCode == CMD_WR_CONFIG && !cfgOk) |=> $stable(cfg_r))
        else $error("bad config accepted");
    a_ptr_bad: assert property (@(posedge clk) disable iff (!rstn)
        (cmdValid && cmdCode == CMD_SET_PTR && !cmdAck) |=> $stable(ptr_r))
        else $error("bad pointer accepted");
endmodule
`default_nettype wire

// ==== bench/swm_line_slave.sv ====
// single-wire bus slave model: wired line with pull-up, may hold the line low
`default_nettype none
module swm_line_slave
(
    // link clock and drives
    input  wire logic lineClk,
    input  wire logic lineOe,
    input  wire logic holdLow,
    // wired line level seen by the master
    output logic      lineIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slaveLow_r; // slave pulldown, moves on the link clock only
    // slave pulldown follows the bench request, like a slave answering in a slot
    always_ff @(posedge lineClk)
    begin
        slaveLow_r <= holdLow;
    end
    // pull-up resistor: a released line goes high, never keeps an old value
    assign lineIn = !(lineOe || slaveLow_r);
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the single-wire master register bank
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin nFail++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench
    import swm_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, lineClk, cmdValid, cmdAck, readAddrAck, holdLow;
    logic lineIn, lineOe, pullupOn, ext_pullup_ctrl_n;
    logic [7:0] cmdCode, cmdParam, readData;
    int compares = 0;
    int nFail = 0;
    int cycles = 0; // timeout counter, ceiling well above the full run
    swm_regs swm_regs_inst (.clk(clk), .rstn(rstn), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdParam(cmdParam), .cmdAck(cmdAck),
        .readAddrAck(readAddrAck), .readDataIn(8'h3C), .readData(readData),
        .lineClk(lineClk), .lineIn(lineIn), .lineOut(), .lineOe(lineOe),
        .pullupOn(pullupOn), .ext_pullup_ctrl_n(ext_pullup_ctrl_n));
    swm_line_slave swm_line_slave_inst (.lineClk(lineClk), .lineOe(lineOe),
        .holdLow(holdLow), .lineIn(lineIn));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("compares %0d nFail %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one command, acknowledge judged in its only cycle
    task automatic cmd(input logic [7:0] c, input logic [7:0] p, input logic ack);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdParam <= p;
        @(negedge clk);
        `CHK("cmdAck", ack, cmdAck)
        @(posedge clk);
        cmdValid <= 1'b0;
    endtask
    // move the pointer, then judge the selected register
    task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
        cmd(CMD_SET_PTR, ptr, 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("readData", e, readData)
    endtask
    // poll busy under a bound; n returns the cycles it stood
    task automatic waitIdle(output int n);
        n = 3;
        repeat (3) @(posedge clk);
        @(negedge clk);
        while (readData[ST_BUSY] !== 1'b0 && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("busy", 1'b0, readData[ST_BUSY])
    endtask
    // host read addressing acknowledge, then judge the sampled level
    task automatic sampleLine(input logic e);
        repeat (6) @(posedge clk);
        readAddrAck <= 1'b1;
        @(posedge clk);
        readAddrAck <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("lineLevel", e, readData[ST_LINE])
        `CHK("noBusy", 1'b0, readData[ST_BUSY])
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(PTR_CONFIG, CFG_RESET_VAL);
        rd(PTR_STATUS, STATUS_RESET_VAL);
        cmd(CMD_WR_CONFIG, 8'h11, 1'b0);
        cmd(CMD_WR_CONFIG, 8'hD2, 1'b1);
        rd(PTR_CONFIG, 8'h00);
        rd(PTR_STATUS, 8'h00);
        cmd(CMD_WR_CONFIG, 8'h78, 1'b1);
        cmd(CMD_WR_CONFIG, 8'h11, 1'b0);
        rd(PTR_CONFIG, 8'h08);
        cmd(CMD_SET_PTR, 8'h55, 1'b0);
        rd(PTR_READ_DATA, 8'h3C);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("readAgain", 8'h3C, readData)
        cmd(CMD_WR_CONFIG, 8'hF0, 1'b1);
    endtask
    task automatic t_busReset();
        int n;
        holdLow <= 1'b1;
        cmd(CMD_BUS_RESET, 8'h00, 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("busyUp", 1'b1, readData[ST_BUSY])
        cmd(CMD_WR_CONFIG, 8'hE1, 1'b0);
        waitIdle(n);
        `CHK("short", 2'b10, readData[ST_SHORT:ST_PRES])
        holdLow <= 1'b0;
        cmd(CMD_BUS_RESET, 8'h00, 1'b1);
        waitIdle(n);
        `CHK("noShort", 1'b0, readData[ST_SHORT])
        cmd(CMD_BUS_RESET, 8'h00, 1'b1);
        repeat (260) @(posedge clk);
        holdLow <= 1'b1;
        waitIdle(n);
        `CHK("presence", 2'b01, readData[ST_SHORT:ST_PRES])
        holdLow <= 1'b0;
    endtask
    task automatic t_bits();
        int n;
        cmd(CMD_SINGLE, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("bitRes", 1'b1, readData[ST_SBR])
        cmd(CMD_TRIPLET, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("triplet", 3'b111, readData[ST_DIR:ST_SBR])
        holdLow <= 1'b1;
        cmd(CMD_SINGLE, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("bitLow", 3'b110, readData[ST_DIR:ST_SBR])
        holdLow <= 1'b0;
    endtask
    task automatic t_strong();
        int n;
        cmd(CMD_WR_CONFIG, 8'hA5, 1'b1);
        cmd(CMD_WR_BYTE, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("extOn", 1'b0, ext_pullup_ctrl_n)
        `CHK("pullHeld", 1'b1, pullupOn)
        cmd(CMD_SINGLE, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("extOff", 1'b1, ext_pullup_ctrl_n)
        rd(PTR_CONFIG, 8'h01);
    endtask
    task automatic t_speed();
        int n;
        cmd(CMD_SINGLE, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("stdSlot", 1'b1, n <= STD_SLOT_CYC + 10)
        cmd(CMD_WR_CONFIG, 8'h78, 1'b1);
        cmd(CMD_SINGLE, 8'hFF, 1'b1);
        waitIdle(n);
        `CHK("ovdSlot", 1'b1, n <= OVD_SLOT_CYC + 10)
        cmd(CMD_WR_CONFIG, 8'hF0, 1'b1);
        cmd(CMD_BUS_RESET, 8'h00, 1'b1);
        waitIdle(n);
        holdLow <= 1'b1;
        sampleLine(1'b0);
        holdLow <= 1'b0;
        sampleLine(1'b1);
    endtask
    task automatic t_devReset();
        cmd(CMD_WR_CONFIG, 8'hE1, 1'b1);
        cmd(CMD_DEV_RESET, 8'h00, 1'b1);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("rstStatus", 8'h10, readData & 8'hF7)
        rd(PTR_CONFIG, 8'h00);
    endtask
    // clocks: host 50 ns, link 30 ns with an unrelated phase
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        lineClk = 1'b0;
        #7;
        forever #15 lineClk = ~lineClk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            nFail++;
            complete_run();
        end
    end
    initial
    begin
        rstn = 1'b0;
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdParam = 8'h00;
        readAddrAck = 1'b0;
        holdLow = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_busReset();
        t_bits();
        t_strong();
        t_speed();
        t_devReset();
        complete_run();
    end
endmodule
`default_nettype wire
